/* File: hw/watchdog_config_decode.sv */
// watchdog whose mode, period, clock and window come from two config bytes
// assumes oscillator ticks arrive asynchronously; core_sleep is on clock
`default_nettype none

module watchdog_config_decode (
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire watchdog_cfg_pkg::apb_req_t apb_req,
	output logic                           pready,
	output logic                           pslverr,
	output logic [31:0]                    prdata,
	input  wire logic [2:0]                osc_ticks,
	input  wire logic                      core_sleep,
	output logic                           watchdog_reset
);
	import watchdog_cfg_pkg::*;

	wd_state_t r;
	wd_state_t n;

	logic             acc;
	logic             wr;
	logic             hit;
	logic [1:0]       mode;
	logic [2:0]       clk_code;
	logic [2:0]       rise;
	logic             tick;
	logic             running;
	logic [4:0]       dlog;
	logic [CNT_W-1:0] divider;
	logic [CNT_W-1:0] shut_lim;
	logic             win_locked;
	logic             kick;
	logic [31:0]      rd_val;

	// por value of the period field
	function automatic logic [4:0] por_period(input logic [4:0] code);
		por_period = (code == PER_SOFT) ? PER_POR_SOFT : code;
	endfunction

	// por value of the window field
	function automatic logic [2:0] por_window(input logic [2:0] code);
		por_window = (code == WIN_OPEN_LOCK) ? WIN_OPEN : code;
	endfunction

	// bus decode, zero wait states
	assign acc = apb_req.psel & apb_req.penable;
	assign wr  = acc & apb_req.pwrite;
	assign hit = (apb_req.paddr == CFG_LO_ADDR) | (apb_req.paddr == CFG_HI_ADDR)
		| (apb_req.paddr == CTL_ADDR) | (apb_req.paddr == KICK_ADDR)
		| (apb_req.paddr == STAT_ADDR) | (apb_req.paddr == EFF_ADDR);
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata  = r.prdata;
	assign watchdog_reset = r.trip;

	// mode and clock choice from the stored configuration
	assign mode = r.cfg_lo[6:5];
	assign clk_code = (r.cfg_hi[5:3] == CLK_SOFT) ? r.rt_clk : r.cfg_hi[5:3];
	assign rise = r.sync_b & ~r.sync_c;

	// reference tick select
	always_comb
	begin
		tick = 1'b0;
		if (mode != MODE_OFF)
		begin
			case (clk_code)
				CLK_LOW: tick = rise[0];
				CLK_MID: tick = rise[1];
				CLK_SEC: tick = rise[2];
				default: tick = 1'b0;
			endcase
		end
	end

	// run decision per mode
	always_comb
	begin
		case (mode)
			MODE_OFF:   running = 1'b0;
			MODE_SOFT:  running = r.soft_on;
			MODE_AWAKE: running = ~core_sleep;
			default:    running = 1'b1;
		endcase
	end

	// divider and closed part of the window
	assign dlog = ((r.rt_period <= PER_MAX) ? r.rt_period : 5'h00) + DIV_LOG2_MIN;
	assign divider = CNT_W'(1) << dlog;
	assign shut_lim = (r.rt_window <= WIN_LAST_SHUT)
		? (CNT_W'(WIN_EIGHTHS - r.rt_window) << (dlog - 5'h03)) : '0;
	assign win_locked = (r.cfg_hi[2:0] != WIN_OPEN);

	// kick write, keyed unless the window is software owned
	assign kick = wr & (apb_req.paddr == KICK_ADDR)
		& (~win_locked | (apb_req.pwdata[7:0] == KICK_KEY));

	// read mux
	always_comb
	begin
		rd_val = '0;
		case (apb_req.paddr)
			CFG_LO_ADDR: rd_val = {24'h00_0000, LO_UNIMPL | {1'b0, r.cfg_lo}};
			CFG_HI_ADDR: rd_val = {24'h00_0000, HI_UNIMPL | {2'b00, r.cfg_hi}};
			CTL_ADDR:    rd_val = {19'h0_0000, 1'b0, r.rt_window, r.rt_period,
				r.rt_clk, r.soft_on};
			STAT_ADDR:   rd_val = {5'h00, running, r.wv_seen, r.to_seen, r.count};
			EFF_ADDR:    rd_val = {19'h0_0000, mode, clk_code, r.rt_window, dlog};
			default:     rd_val = '0;
		endcase
	end

	// next state
	always_comb
	begin
		n = r;
		n.trip = 1'b0;
		n.sync_a = osc_ticks;
		n.sync_b = r.sync_a;
		n.sync_c = r.sync_b;
		if (apb_req.psel & ~apb_req.penable)
			n.prdata = rd_val;
		// capture of the configuration into runtime settings
		if (r.load_pend)
		begin
			n.load_pend = 1'b0;
			n.rt_period = por_period(r.cfg_lo[4:0]);
			n.rt_window = por_window(r.cfg_hi[2:0]);
			n.rt_clk    = CLK_LOW;
			n.soft_on   = 1'b0;
			n.count     = '0;
		end
		// register writes
		if (wr)
		begin
			case (apb_req.paddr)
				CFG_LO_ADDR: n.cfg_lo = apb_req.pwdata[6:0];
				CFG_HI_ADDR: n.cfg_hi = apb_req.pwdata[5:0];
				CTL_ADDR:
				begin
					n.soft_on = apb_req.pwdata[CTL_ON];
					if (r.cfg_hi[5:3] == CLK_SOFT)
						n.rt_clk = apb_req.pwdata[CTL_CLK +: 3];
					if (r.cfg_lo[4:0] == PER_SOFT)
						n.rt_period = apb_req.pwdata[CTL_PER +: 5];
					if (!win_locked)
						n.rt_window = apb_req.pwdata[CTL_WIN +: 3];
					if (apb_req.pwdata[CTL_RELOAD])
						n.load_pend = 1'b1;
				end
				STAT_ADDR:
				begin
					if (apb_req.pwdata[STAT_TO])
						n.to_seen = 1'b0;
					if (apb_req.pwdata[STAT_WV])
						n.wv_seen = 1'b0;
				end
				default: n.prdata = r.prdata;
			endcase
		end
		// counting, kicks and time-out; sets come after clears
		if (mode == MODE_OFF)
			n.count = '0;
		else if (kick)
		begin
			n.count = '0;
			if (running && (r.count < shut_lim))
			begin
				n.trip = 1'b1;
				n.wv_seen = 1'b1;
			end
		end
		else if (running && tick && !r.load_pend)
		begin
			if (r.count == divider - CNT_W'(1))
			begin
				n.count = '0;
				n.trip = 1'b1;
				n.to_seen = 1'b1;
			end
			else
				n.count = r.count + CNT_W'(1);
		end
	end

	// state register, synchronous reset to blank configuration
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.cfg_lo <= CFG_LO_BLANK;
			r.cfg_hi <= CFG_HI_BLANK;
			r.load_pend <= 1'b1;
		end
		else
			r <= n;
	end

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence lo_read_s;
		apb_req.psel && !apb_req.penable && !apb_req.pwrite
			&& apb_req.paddr == CFG_LO_ADDR;
	endsequence

	sequence hi_read_s;
		apb_req.psel && !apb_req.penable && !apb_req.pwrite
			&& apb_req.paddr == CFG_HI_ADDR;
	endsequence

	sequence ctl_write_s;
		wr && apb_req.paddr == CTL_ADDR;
	endsequence

	unimpl_lo_a: assert property (lo_read_s |=> prdata[7])
		else $error("low config bit 7 not read as one");
	unimpl_hi_a: assert property (hi_read_s |=> prdata[7:6] == 2'b11)
		else $error("high config bits 7-6 not read as one");
	blank_load_a: assert property ($rose(rst_n) |-> r.cfg_lo == CFG_LO_BLANK
		&& r.cfg_hi == CFG_HI_BLANK ##1 r.rt_period == PER_POR_SOFT)
		else $error("blank configuration not loaded");
	mode_off_a: assert property (mode == MODE_OFF |-> !running && !tick ##1 r.count == '0)
		else $error("watchdog active in off mode");
	soft_mode_a: assert property (mode == MODE_SOFT |-> running == r.soft_on)
		else $error("soft mode ignores enable bit");
	sleep_hold_a: assert property (mode == MODE_AWAKE && core_sleep && !kick
		&& !r.load_pend |=> r.count == $past(r.count))
		else $error("count moved during sleep");
	always_on_a: assert property (mode == MODE_ON |-> running)
		else $error("always-on mode not running");
	timeout_at_a: assert property (running && tick && !kick && !r.load_pend
		&& mode != MODE_OFF && r.count == divider - CNT_W'(1)
		|=> watchdog_reset && r.count == '0)
		else $error("time-out not at divider count");
	min_div_a: assert property (r.rt_period > PER_MAX |-> dlog == DIV_LOG2_MIN)
		else $error("out of range period not 1:32");
	per_lock_a: assert property (ctl_write_s ##0 (r.cfg_lo[4:0] != PER_SOFT && !r.load_pend)
		|=> r.rt_period == $past(r.rt_period))
		else $error("locked period changed by software");
	per_soft_a: assert property (ctl_write_s ##0 (r.cfg_lo[4:0] == PER_SOFT)
		|=> r.rt_period == $past(apb_req.pwdata[8:4]))
		else $error("soft period write lost");
	clk_pick_a: assert property (mode != MODE_OFF && r.cfg_hi[5:3] == CLK_MID
		|-> tick == rise[1])
		else $error("mid oscillator not selected");
	clk_resv_a: assert property (r.cfg_hi[5:3] inside {[3'h3:3'h6]} |-> !tick)
		else $error("reserved clock code ticks");
	win_shut_a: assert property (kick && running && mode != MODE_OFF
		&& r.count < shut_lim |=> watchdog_reset ##1 !watchdog_reset)
		else $error("kick in closed window not caught");
	win_lock_a: assert property (ctl_write_s ##0 (win_locked && !r.load_pend)
		|=> r.rt_window == $past(r.rt_window))
		else $error("locked window changed by software");
	win_soft_a: assert property (ctl_write_s ##0 !win_locked
		|=> r.rt_window == $past(apb_req.pwdata[11:9]))
		else $error("soft window write lost");
	por_cap_a: assert property (r.load_pend && !wr |=> r.rt_window
		== por_window($past(r.cfg_hi[2:0])) && r.count == '0)
		else $error("window not captured at reset");

endmodule

`default_nettype wire

/* File: hw/watchdog_cfg_pkg.sv */
// watchdog configuration decode: constants, field layout and carrier types
// assumes a 32-bit APB master and a 10 MHz system clock
// Operation
// - unimplemented configuration bits read back as one
// - blank device: every configuration bit reads one
// - mode 00: watchdog off, software enable ignored
// - mode 01: software enable bit runs watchdog
// - mode 10: counts awake, suspended during sleep
// - mode 11: counts always, sleep or not
// - period codes 0-18 double divider 1:32 upward
// - codes 19-30 fix divider 1:32, locked
// - code 31 loads 01011 at reset, writable
// - clock field ignored when mode is 00
// - clock codes select low, mid, secondary oscillator
// - clock codes 3-6 reserved, 7 software select
// - window codes 0-5 fixed, need keyed kick
`default_nettype none

package watchdog_cfg_pkg;

	// configuration byte indices; byte address is four times the index
	localparam logic [31:0] CFG_LO_IDX  = 32'h0030_0004;
	localparam logic [31:0] CFG_HI_IDX  = 32'h0030_0005;
	localparam logic [31:0] CFG_LO_ADDR = 32'h00C0_0010;
	localparam logic [31:0] CFG_HI_ADDR = 32'h00C0_0014;
	// block control and status words
	localparam logic [31:0] CTL_ADDR    = 32'h0000_0000;
	localparam logic [31:0] KICK_ADDR   = 32'h0000_0004;
	localparam logic [31:0] STAT_ADDR   = 32'h0000_0008;
	localparam logic [31:0] EFF_ADDR    = 32'h0000_000C;

	// blank values and unimplemented bits
	localparam logic [6:0] CFG_LO_BLANK = 7'h7F;
	localparam logic [5:0] CFG_HI_BLANK = 6'h3F;
	localparam logic [7:0] LO_UNIMPL    = 8'h80;
	localparam logic [7:0] HI_UNIMPL    = 8'hC0;

	// operating modes
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_SOFT  = 2'h1;
	localparam logic [1:0] MODE_AWAKE = 2'h2;
	localparam logic [1:0] MODE_ON    = 2'h3;

	// period codes
	localparam logic [4:0] PER_MAX      = 5'h12;
	localparam logic [4:0] PER_SOFT     = 5'h1F;
	localparam logic [4:0] PER_POR_SOFT = 5'h0B;
	localparam logic [4:0] DIV_LOG2_MIN = 5'h05;

	// window codes
	localparam logic [2:0] WIN_LAST_SHUT = 3'h5;
	localparam logic [2:0] WIN_OPEN_LOCK = 3'h6;
	localparam logic [2:0] WIN_OPEN      = 3'h7;
	localparam logic [2:0] WIN_EIGHTHS   = 3'h7;

	// reference clock codes
	localparam logic [2:0] CLK_LOW   = 3'h0;
	localparam logic [2:0] CLK_MID   = 3'h1;
	localparam logic [2:0] CLK_SEC   = 3'h2;
	localparam logic [2:0] CLK_SOFT  = 3'h7;

	// control and status word fields and kick key
	localparam int CTL_ON     = 0;
	localparam int CTL_CLK    = 1;
	localparam int CTL_PER    = 4;
	localparam int CTL_WIN    = 9;
	localparam int CTL_RELOAD = 12;
	localparam int STAT_TO    = 24;
	localparam int STAT_WV    = 25;
	localparam int STAT_RUN   = 26;
	localparam logic [7:0] KICK_KEY = 8'h5A;

	localparam int CNT_W = 24;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [6:0]       cfg_lo;
		logic [5:0]       cfg_hi;
		logic             load_pend;
		logic [4:0]       rt_period;
		logic [2:0]       rt_window;
		logic [2:0]       rt_clk;
		logic             soft_on;
		logic [2:0]       sync_a;
		logic [2:0]       sync_b;
		logic [2:0]       sync_c;
		logic [CNT_W-1:0] count;
		logic             trip;
		logic             to_seen;
		logic             wv_seen;
		logic [31:0]      prdata;
	} wd_state_t;

endpackage

`default_nettype wire

/* File: verif/watchdog_config_decode_tb_top.sv */
// bench for the watchdog configuration decode block over APB
// assumes a zero-wait slave and oscillator ticks driven slowly by the bench
`default_nettype none
`define CHK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end

module watchdog_config_decode_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import watchdog_cfg_pkg::*;

	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	apb_req_t    req = '0;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic [2:0]  osc_ticks = 3'h0;
	logic        core_sleep = 1'b0;
	logic        watchdog_reset;
	logic [31:0] rdata;
	logic        rerr;
	logic [4:0]  e5;
	logic [4:0]  pcode [6] = '{5'h00, 5'h01, 5'h12, 5'h13, 5'h1E, 5'h1F};
	int          fail_count = 0;
	int          n_tests = 0;
	int          pulses = 0;
	int          cycles = 0;
	int          p0;

	watchdog_config_decode dut (
		.clock          (clock),
		.rst_n          (rst_n),
		.apb_req        (req),
		.pready         (pready),
		.pslverr        (pslverr),
		.prdata         (prdata),
		.osc_ticks      (osc_ticks),
		.core_sleep     (core_sleep),
		.watchdog_reset (watchdog_reset)
	);

	// free-running 10 MHz clock
	always #50 clock = ~clock;

	// count time-out pulses; cut a hang short
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (watchdog_reset === 1'b1)
			pulses <= pulses + 1;
		if (cycles == 40000)
		begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one APB transfer; answer taken at the edge that sees pready
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// write both bytes, recapture, clear the count
	task automatic cfg(input logic [7:0] lo, input logic [7:0] hi);
		bus(1'b1, CFG_LO_ADDR, {24'h0, lo});
		bus(1'b1, CFG_HI_ADDR, {24'h0, hi});
		bus(1'b1, CTL_ADDR, 32'h0000_1000);
		if (hi[2:0] == 3'h7)
			bus(1'b1, KICK_ADDR, 32'h0);
	endtask

	// n slow rising edges on one oscillator input
	task automatic tick(input int idx, input int n);
		repeat (n)
		begin
			osc_ticks[idx] <= 1'b1;
			repeat (3) @(posedge clock);
			osc_ticks[idx] <= 1'b0;
			repeat (3) @(posedge clock);
		end
		repeat (4) @(posedge clock);
	endtask

	task automatic count_is(input logic [23:0] e);
		bus(1'b0, STAT_ADDR, 32'h0);
		`CHK(rdata[23:0], e)
	endtask

	initial
	begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		// blank bytes and settings captured from them
		bus(1'b0, CFG_LO_ADDR, 32'h0);
		`CHK(rdata, 32'h0000_00FF)
		bus(1'b0, CFG_HI_ADDR, 32'h0);
		`CHK(rdata, 32'h0000_00FF)
		bus(1'b0, EFF_ADDR, 32'h0);
		`CHK({rdata[12:11], rdata[7:5], rdata[4:0]}, 10'h3F0)
		bus(1'b1, CFG_LO_ADDR, 32'h0);
		bus(1'b0, CFG_LO_ADDR, 32'h0);
		`CHK(rdata[7:0], 8'h80)
		bus(1'b1, CFG_HI_ADDR, 32'h0);
		bus(1'b0, CFG_HI_ADDR, 32'h0);
		`CHK(rdata[7:0], 8'hC0)
		bus(1'b0, 32'h0000_0100, 32'h0);
		`CHK({rerr, rdata}, 33'h1_0000_0000)
		// period codes, then a software period write
		foreach (pcode[i])
		begin
			cfg({3'h7, pcode[i]}, 8'h07);
			e5 = (pcode[i] <= 5'h12) ? pcode[i] + 5'h05 : ((pcode[i] == 5'h1F) ? 5'h10 : 5'h05);
			bus(1'b0, EFF_ADDR, 32'h0);
			`CHK(rdata[4:0], e5)
			bus(1'b1, CTL_ADDR, 32'h0000_0020);
			e5 = (pcode[i] == 5'h1F) ? 5'h07 : e5;
			bus(1'b0, EFF_ADDR, 32'h0);
			`CHK(rdata[4:0], e5)
		end
		// window codes, then a software window write
		for (int w = 0; w < 8; w++)
		begin
			cfg(8'h60, {5'h00, w[2:0]});
			bus(1'b0, EFF_ADDR, 32'h0);
			`CHK(rdata[7:5], (w >= 6) ? 3'h7 : w[2:0])
			bus(1'b1, CTL_ADDR, 32'h0000_0600);
			bus(1'b0, EFF_ADDR, 32'h0);
			`CHK(rdata[7:5], (w == 7) ? 3'h3 : ((w == 6) ? 3'h7 : w[2:0]))
		end
		// time-out on exactly the 32nd tick at the smallest divider
		cfg(8'h60, 8'h07);
		p0 = pulses;
		tick(0, 31);
		`CHK(pulses - p0, 0)
		tick(0, 1);
		`CHK(pulses - p0, 1)
		bus(1'b0, STAT_ADDR, 32'h0);
		`CHK(rdata[24], 1'b1)
		// each reference clock code counts its own oscillator and ignores the next one
		for (int c = 0; c < 3; c++)
		begin
			cfg(8'h60, {2'h0, c[2:0], 3'h7});
			tick((c + 1) % 3, 3);
			count_is(24'h0);
			tick(c, 3);
			count_is(24'h3);
		end
		cfg(8'h60, 8'h3F);
		bus(1'b1, CTL_ADDR, 32'h0000_0002);
		tick(1, 2);
		count_is(24'h2);
		// mode 00 ignores enable and clock field
		cfg(8'h00, 8'h0F);
		bus(1'b1, CTL_ADDR, 32'h0000_0001);
		tick(1, 3);
		count_is(24'h0);
		`CHK(rdata[26], 1'b0)
		// mode 01 follows the software enable
		cfg(8'h20, 8'h07);
		tick(0, 3);
		count_is(24'h0);
		bus(1'b1, CTL_ADDR, 32'h0000_0001);
		tick(0, 3);
		count_is(24'h3);
		// mode 10 freezes asleep, mode 11 does not
		cfg(8'h40, 8'h07);
		core_sleep <= 1'b1;
		tick(0, 3);
		count_is(24'h0);
		core_sleep <= 1'b0;
		tick(0, 3);
		count_is(24'h3);
		cfg(8'h60, 8'h07);
		core_sleep <= 1'b1;
		tick(0, 2);
		count_is(24'h2);
		core_sleep <= 1'b0;
		// closed window: keyed early kick trips, unkeyed kick ignored
		cfg(8'h60, 8'h00);
		p0 = pulses;
		bus(1'b1, KICK_ADDR, 32'h0000_005A);
		bus(1'b0, STAT_ADDR, 32'h0);
		`CHK({rdata[25], pulses - p0}, {1'b1, 32'd1})
		tick(0, 2);
		bus(1'b1, KICK_ADDR, 32'h0);
		count_is(24'h2);
		`CHK(pulses - p0, 1)
		// open window: unkeyed kick clears a nonzero count
		cfg(8'h60, 8'h07);
		tick(0, 2);
		count_is(24'h2);
		bus(1'b1, KICK_ADDR, 32'h0);
		count_is(24'h0);
		stop_test();
	end
endmodule

`default_nettype wire
